// ===== drive_common_param_map.sv
// Common parameter map of the drive: word registers behind the serial protocol engine.
// Assumes the protocol engine runs on clk_in, presents one word access at a time
// as ASCII hex characters and turns the refusal code into its negative answer.
`timescale 1ns/100ps
`default_nettype none
`include "drive_map_params.svh"

// Behaviour
// - Fixed addresses, same on every model
// - Bits 0-2 request stop, forward, reverse
// - Bit 3 resets fault on rising edge
// - Bit 4 emergency stop; bit 5 ignored
// - Bits 6-7 show run command source
// - Bits 8-14 show frequency reference source
// - Bit 15 set on network error
// - Status bits 0-5: stop, run, trip, ramps
// - Status bits 6-14: arrival, braking, commands, remote
// - Fault bits 0-6 basic trip flags
// - Fault bits 6-15 thermal, overload, hardware flags
// - Words travel as four hex characters
// - Read-only writes refused as write-mode error
// - Out-of-range writes refused, value kept
// - Command bits act on written rising edge
module drive_common_param_map
	import drive_map_pkg::*;
#(
	parameter logic [15:0] MODEL_CODE         = 16'h00A5, // Arbitrary
	parameter logic [15:0] POWER_RATING_CODE  = 16'h0000,
	parameter logic [15:0] SUPPLY_CLASS       = 16'h0001,
	parameter logic [15:0] FIRMWARE_REVISION  = 16'h0ABC, // Arbitrary
	parameter logic [15:0] CUSTOM_REVISION    = 16'h0DEF, // Arbitrary
	parameter logic [15:0] SPEED_SETPOINT_MAX = `SPEED_SETPOINT_MAX,
	parameter logic [15:0] RAMP_TIME_MAX      = `RAMP_TIME_MAX
) (
	// Clock, reset, enable
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         ce_in,
	// Word access from the protocol engine
	input  wire logic         acc_valid_in,
	input  wire logic         acc_write_in,
	input  wire logic [15:0]  acc_addr_in,
	input  wire logic [31:0]  acc_chars_in,
	input  wire logic         net_error_in,
	// Answer to the protocol engine
	output logic              ans_valid_out,
	output err_code_t         ans_error_out,
	output logic      [31:0]  ans_chars_out,
	// Drive core state
	input  wire core_status_t core_status_in,
	input  wire fault_in_t    fault_in,
	input  wire drive_meas_t  meas_in,
	input  wire logic [1:0]   run_source_in,
	input  wire logic [6:0]   freq_source_in,
	input  wire logic [15:0]  unit_select_in,
	input  wire logic [15:0]  pole_count_in,
	input  wire logic [7:0]   out_pins_state_in,
	// Terminal pins
	input  wire logic [7:0]   in_pins_in,
	// Commands and settings to the drive core
	output run_cmd_t          cmd_out,
	output logic      [15:0]  speed_setpoint_out,
	output logic      [15:0]  ramp_up_time_out,
	output logic      [15:0]  ramp_down_time_out,
	output logic              fwd_cmd_out,
	output logic              rev_cmd_out,
	output logic              net_error_flag_out
);

	initial begin
		if (SPEED_SETPOINT_MAX == 16'h0000 || RAMP_TIME_MAX == 16'h0000) begin
			$error("drive_common_param_map limits must be above zero");
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Terminal pin synchroniser

	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic [7:0] next_pin_meta;
	logic [7:0] next_pin_sync;

	always_comb begin
		next_pin_meta = ce_in ? in_pins_in : pin_meta;
		next_pin_sync = ce_in ? pin_meta : pin_sync;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			pin_meta <= next_pin_meta;
			pin_sync <= next_pin_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Character conversion

	logic [15:0] wr_word;
	logic        wr_chars_ok;
	logic [15:0] rd_word;
	logic [31:0] rd_chars;

	ascii_hex_word #(
		.NIBBLES (4)
	) u_wr_codec (
		.word_in      (16'h0000),
		.chars_out    (),
		.chars_in     (acc_chars_in),
		.word_out     (wr_word),
		.chars_ok_out (wr_chars_ok)
	);

	ascii_hex_word #(
		.NIBBLES (4)
	) u_rd_codec (
		.word_in      (rd_word),
		.chars_out    (rd_chars),
		.chars_in     (32'h30303030),
		.word_out     (),
		.chars_ok_out ()
	);

	////////////////////////////////////////////////////////////////////////////
	// Stored words and the composed read-only words

	logic [15:0]              speed_setpoint;
	logic [15:0]              ramp_up_time;
	logic [15:0]              ramp_down_time;
	logic [`RUN_CMD_BITS-1:0] run_bits;
	logic                     net_err;
	logic                     fwd_cmd;
	logic                     rev_cmd;
	logic [`RUN_CMD_BITS-1:0] run_rise;
	logic [15:0]              run_word;
	logic [15:0]              state_word;
	logic [15:0]              fault_word;

	always_comb begin
		run_word                                 = 16'h0000;
		run_word[`RUN_CMD_BITS-1:0]              = run_bits;
		run_word[`RUN_SRC_MSB:`RUN_SRC_LSB]      = run_source_in;
		run_word[`FREQ_SRC_MSB:`FREQ_SRC_LSB]    = freq_source_in;
		run_word[`RUN_BIT_NET_ERROR]             = net_err;
	end

	// operating status word, bits 9 and 15 left clear
	always_comb begin
		state_word     = 16'h0000;
		state_word[0]  = core_status_in.stopped;
		state_word[1]  = core_status_in.fwd_running;
		state_word[2]  = core_status_in.rev_running;
		state_word[3]  = core_status_in.tripped;
		state_word[4]  = core_status_in.accelerating;
		state_word[5]  = core_status_in.decelerating;
		state_word[6]  = core_status_in.speed_reached;
		state_word[7]  = core_status_in.dc_braking;
		state_word[8]  = core_status_in.stopping;
		state_word[10] = core_status_in.brake_open;
		state_word[11] = fwd_cmd;
		state_word[12] = rev_cmd;
		state_word[13] = (run_source_in == `RUN_SRC_SERIAL) ||
			(run_source_in == `RUN_SRC_OPTION);
		state_word[14] = (freq_source_in == `FREQ_SRC_SERIAL) ||
			(freq_source_in == `FREQ_SRC_OPTION);
	end

	// fault flags; two faults share bit 6, bits 5, 9, 11 stay clear
	always_comb begin
		fault_word     = 16'h0000;
		fault_word[0]  = fault_in.overcurrent_one;
		fault_word[1]  = fault_in.overvoltage_fault;
		fault_word[2]  = fault_in.external_fault_a;
		fault_word[3]  = fault_in.output_inhibit;
		fault_word[4]  = fault_in.undervoltage_fault;
		fault_word[6]  = fault_in.ground_fault | fault_in.drive_overheat;
		fault_word[7]  = fault_in.motor_thermal;
		fault_word[8]  = fault_in.overload_trip;
		fault_word[10] = fault_in.hardware_diag_fault;
		fault_word[12] = fault_in.overcurrent_two;
		fault_word[13] = fault_in.option_card_error;
		fault_word[14] = fault_in.phase_loss;
		fault_word[15] = fault_in.drive_overload;
	end

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	logic        addr_known;
	logic        addr_writable;
	logic [15:0] addr_word;

	// fixed map, raw scaled counts, holes refused
	always_comb begin
		addr_known    = 1'b1;
		addr_writable = 1'b0;
		addr_word     = 16'h0000;
		case (acc_addr_in)
			`ADDR_MODEL_CODE:          addr_word = MODEL_CODE;
			`ADDR_POWER_RATING_CODE:   addr_word = POWER_RATING_CODE;
			`ADDR_SUPPLY_CLASS:        addr_word = SUPPLY_CLASS;
			`ADDR_FIRMWARE_REVISION:   addr_word = FIRMWARE_REVISION;
			`ADDR_SPEED_SETPOINT: begin
				addr_word     = speed_setpoint;
				addr_writable = 1'b1;
			end
			`ADDR_RUN_CONTROL_WORD: begin
				addr_word     = run_word;
				addr_writable = 1'b1;
			end
			`ADDR_RAMP_UP_TIME: begin
				addr_word     = ramp_up_time;
				addr_writable = 1'b1;
			end
			`ADDR_RAMP_DOWN_TIME: begin
				addr_word     = ramp_down_time;
				addr_writable = 1'b1;
			end
			`ADDR_LOAD_CURRENT:        addr_word = meas_in.load_current;
			`ADDR_OUTPUT_FREQ_NOW:     addr_word = meas_in.output_freq_now;
			`ADDR_OUTPUT_VOLTS:        addr_word = meas_in.output_volts;
			`ADDR_BUS_VOLTS:           addr_word = meas_in.bus_volts;
			`ADDR_OUTPUT_POWER_NOW:    addr_word = meas_in.output_power_now;
			`ADDR_DRIVE_STATE_WORD:    addr_word = state_word;
			`ADDR_FAULT_FLAG_WORD:     addr_word = fault_word;
			`ADDR_INPUT_PINS_STATE:    addr_word = {8'h00, pin_sync};
			`ADDR_OUTPUT_PINS_STATE:   addr_word = {8'h00, out_pins_state_in};
			`ADDR_ANALOG_VOLT_IN_ONE:  addr_word = meas_in.analog_volt_in_one;
			`ADDR_ANALOG_VOLT_IN_TWO:  addr_word = meas_in.analog_volt_in_two;
			`ADDR_CURRENT_LOOP_IN:     addr_word = meas_in.current_loop_in;
			`ADDR_SHAFT_SPEED:         addr_word = meas_in.shaft_speed;
			`ADDR_DISPLAY_UNIT_SELECT: addr_word = unit_select_in;
			`ADDR_MOTOR_POLE_COUNT:    addr_word = pole_count_in;
			`ADDR_CUSTOM_REVISION:     addr_word = CUSTOM_REVISION;
			default:                   addr_known = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Access check

	err_code_t acc_error;
	logic      value_ok;
	logic      do_write;

	always_comb begin
		value_ok = wr_chars_ok;
		case (acc_addr_in)
			`ADDR_SPEED_SETPOINT:   value_ok = wr_chars_ok && (wr_word <= SPEED_SETPOINT_MAX);
			`ADDR_RAMP_UP_TIME:     value_ok = wr_chars_ok && (wr_word <= RAMP_TIME_MAX);
			`ADDR_RAMP_DOWN_TIME:   value_ok = wr_chars_ok && (wr_word <= RAMP_TIME_MAX);
			default:                value_ok = wr_chars_ok;
		endcase
	end

	// address first, then write mode, then value
	always_comb begin
		acc_error = ERR_NONE;
		if (!addr_known) begin
			acc_error = ERR_ILLEGAL_ADDR;
		end else if (acc_write_in && !addr_writable) begin
			acc_error = ERR_WRITE_MODE;
		end else if (acc_write_in && !value_ok) begin
			acc_error = ERR_ILLEGAL_VALUE;
		end
	end

	assign do_write = ce_in && acc_valid_in && acc_write_in && (acc_error == ERR_NONE);
	assign rd_word  = addr_word;

	////////////////////////////////////////////////////////////////////////////
	// Writable words

	logic [15:0]              next_speed_setpoint;
	logic [15:0]              next_ramp_up_time;
	logic [15:0]              next_ramp_down_time;
	logic [`RUN_CMD_BITS-1:0] next_run_bits;
	logic                     next_net_err;
	logic                     ctl_write;

	assign ctl_write = do_write && (acc_addr_in == `ADDR_RUN_CONTROL_WORD);

	always_comb begin
		next_speed_setpoint = speed_setpoint;
		next_ramp_up_time   = ramp_up_time;
		next_ramp_down_time = ramp_down_time;
		next_run_bits       = run_bits;
		if (do_write && acc_addr_in == `ADDR_SPEED_SETPOINT) begin
			next_speed_setpoint = wr_word;
		end
		if (do_write && acc_addr_in == `ADDR_RAMP_UP_TIME) begin
			next_ramp_up_time = wr_word;
		end
		if (do_write && acc_addr_in == `ADDR_RAMP_DOWN_TIME) begin
			next_ramp_down_time = wr_word;
		end
		// command bits stored, bit 5 dropped
		if (ctl_write) begin
			next_run_bits = wr_word[`RUN_CMD_BITS-1:0];
		end
		// a new error beats a clearing write
		next_net_err = net_err;
		if (ctl_write && !wr_word[`RUN_BIT_NET_ERROR]) begin
			next_net_err = 1'b0;
		end
		if (ce_in && net_error_in) begin
			next_net_err = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			speed_setpoint <= `SPEED_SETPOINT_RESET;
			ramp_up_time   <= `RAMP_UP_RESET;
			ramp_down_time <= `RAMP_DOWN_RESET;
			run_bits       <= '0;
			net_err        <= 1'b0;
		end else begin
			speed_setpoint <= next_speed_setpoint;
			ramp_up_time   <= next_ramp_up_time;
			ramp_down_time <= next_ramp_down_time;
			run_bits       <= next_run_bits;
			net_err        <= next_net_err;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command pulses and direction latch

	edge_pulse #(
		.WIDTH (`RUN_CMD_BITS)
	) u_cmd_edge (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.level_in (run_bits),
		.rise_out (run_rise)
	);

	logic next_fwd_cmd;
	logic next_rev_cmd;

	// latched direction for status bits 11 and 12
	always_comb begin
		next_fwd_cmd = fwd_cmd;
		next_rev_cmd = rev_cmd;
		if (run_rise[`RUN_BIT_FORWARD]) begin
			next_fwd_cmd = 1'b1;
			next_rev_cmd = 1'b0;
		end
		if (run_rise[`RUN_BIT_REVERSE]) begin
			next_fwd_cmd = 1'b0;
			next_rev_cmd = 1'b1;
		end
		// Stop rises win so a write raising a stop bit never leaves the motor commanded
		if (run_rise[`RUN_BIT_STOP] || run_rise[`RUN_BIT_ESTOP]) begin
			next_fwd_cmd = 1'b0;
			next_rev_cmd = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fwd_cmd <= 1'b0;
			rev_cmd <= 1'b0;
		end else begin
			fwd_cmd <= next_fwd_cmd;
			rev_cmd <= next_rev_cmd;
		end
	end

	always_comb begin
		cmd_out.stop        = run_rise[`RUN_BIT_STOP];
		cmd_out.forward     = run_rise[`RUN_BIT_FORWARD];
		cmd_out.reverse     = run_rise[`RUN_BIT_REVERSE];
		cmd_out.fault_reset = run_rise[`RUN_BIT_FAULT_RESET];
		cmd_out.estop       = run_rise[`RUN_BIT_ESTOP];
	end

	////////////////////////////////////////////////////////////////////////////
	// Answer register

	logic        next_ans_valid;
	err_code_t   next_ans_error;
	logic [31:0] next_ans_chars;

	// Accepted writes answer the word as it stood before the write
	always_comb begin
		next_ans_valid = ans_valid_out;
		next_ans_error = ans_error_out;
		next_ans_chars = ans_chars_out;
		if (ce_in) begin
			next_ans_valid = acc_valid_in;
			if (acc_valid_in) begin
				next_ans_error = acc_error;
				next_ans_chars = (acc_error == ERR_NONE) ? rd_chars : 32'h30303030;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ans_valid_out <= 1'b0;
			ans_error_out <= ERR_NONE;
			ans_chars_out <= 32'h30303030;
		end else begin
			ans_valid_out <= next_ans_valid;
			ans_error_out <= next_ans_error;
			ans_chars_out <= next_ans_chars;
		end
	end

	assign speed_setpoint_out = speed_setpoint;
	assign ramp_up_time_out   = ramp_up_time;
	assign ramp_down_time_out = ramp_down_time;
	assign fwd_cmd_out        = fwd_cmd;
	assign rev_cmd_out        = rev_cmd;
	assign net_error_flag_out = net_err;

endmodule // drive_common_param_map

`default_nettype wire

// ===== drive_map_params.svh
// Offsets, field positions, reset values and limits of the common parameter map.
// Assumes inclusion by bare name from the package and the map module.
`ifndef DRIVE_MAP_PARAMS_SVH
`define DRIVE_MAP_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Word addresses
`define ADDR_MODEL_CODE          16'h0000
`define ADDR_POWER_RATING_CODE   16'h0001
`define ADDR_SUPPLY_CLASS        16'h0002
`define ADDR_FIRMWARE_REVISION   16'h0003
`define ADDR_SPEED_SETPOINT      16'h0005
`define ADDR_RUN_CONTROL_WORD    16'h0006
`define ADDR_RAMP_UP_TIME        16'h0007
`define ADDR_RAMP_DOWN_TIME      16'h0008
`define ADDR_LOAD_CURRENT        16'h0009
`define ADDR_OUTPUT_FREQ_NOW     16'h000A
`define ADDR_OUTPUT_VOLTS        16'h000B
`define ADDR_BUS_VOLTS           16'h000C
`define ADDR_OUTPUT_POWER_NOW    16'h000D
`define ADDR_DRIVE_STATE_WORD    16'h000E
`define ADDR_FAULT_FLAG_WORD     16'h000F
`define ADDR_INPUT_PINS_STATE    16'h0010
`define ADDR_OUTPUT_PINS_STATE   16'h0011
`define ADDR_ANALOG_VOLT_IN_ONE  16'h0012
`define ADDR_ANALOG_VOLT_IN_TWO  16'h0013
`define ADDR_CURRENT_LOOP_IN     16'h0014
`define ADDR_SHAFT_SPEED         16'h0015
`define ADDR_DISPLAY_UNIT_SELECT 16'h001A
`define ADDR_MOTOR_POLE_COUNT    16'h001B
`define ADDR_CUSTOM_REVISION     16'h001C

////////////////////////////////////////////////////////////////////////////////
// Run control word fields
`define RUN_BIT_STOP        0
`define RUN_BIT_FORWARD     1
`define RUN_BIT_REVERSE     2
`define RUN_BIT_FAULT_RESET 3
`define RUN_BIT_ESTOP       4
`define RUN_CMD_BITS        5
`define RUN_SRC_LSB         6
`define RUN_SRC_MSB         7
`define FREQ_SRC_LSB        8
`define FREQ_SRC_MSB        14
`define RUN_BIT_NET_ERROR   15
`define RUN_SRC_OPTION      2'h2
`define RUN_SRC_SERIAL      2'h3
`define FREQ_SRC_SERIAL     7'h1C
`define FREQ_SRC_OPTION     7'h1D

////////////////////////////////////////////////////////////////////////////////
// Reset values and range limits
`define SPEED_SETPOINT_RESET 16'h0000
`define RAMP_UP_RESET        16'h0032
`define RAMP_DOWN_RESET      16'h0032
`define SPEED_SETPOINT_MAX   16'h9C40
`define RAMP_TIME_MAX        16'h1770

`endif

// ===== drive_map_pkg.sv
// Types shared by the common parameter map, its checker and its bench.
// Assumes drive_map_params.svh sits in the same folder.
`include "drive_map_params.svh"

package drive_map_pkg;

	// Refusal codes returned to the serial protocol engine
	typedef enum logic [1:0] {
		ERR_NONE          = 2'b00,
		ERR_WRITE_MODE    = 2'b01,
		ERR_ILLEGAL_VALUE = 2'b10,
		ERR_ILLEGAL_ADDR  = 2'b11
	} err_code_t;

	typedef struct packed {
		logic stopped;
		logic fwd_running;
		logic rev_running;
		logic tripped;
		logic accelerating;
		logic decelerating;
		logic speed_reached;
		logic dc_braking;
		logic stopping;
		logic brake_open;
	} core_status_t;

	typedef struct packed {
		logic overcurrent_one;
		logic overvoltage_fault;
		logic external_fault_a;
		logic output_inhibit;
		logic undervoltage_fault;
		logic ground_fault;
		logic drive_overheat;
		logic motor_thermal;
		logic overload_trip;
		logic hardware_diag_fault;
		logic overcurrent_two;
		logic option_card_error;
		logic phase_loss;
		logic drive_overload;
	} fault_in_t;

	typedef struct packed {
		logic [15:0] load_current;
		logic [15:0] output_freq_now;
		logic [15:0] output_volts;
		logic [15:0] bus_volts;
		logic [15:0] output_power_now;
		logic [15:0] analog_volt_in_one;
		logic [15:0] analog_volt_in_two;
		logic [15:0] current_loop_in;
		logic [15:0] shaft_speed;
	} drive_meas_t;

	typedef struct packed {
		logic stop;
		logic forward;
		logic reverse;
		logic fault_reset;
		logic estop;
	} run_cmd_t;

endpackage : drive_map_pkg

// ===== ascii_hex_word.sv
// Converts a 16-bit word to four ASCII hex characters and back, high nibble first.
// Purely combinational; the caller registers whatever leaves the block.
`timescale 1ns/100ps
`default_nettype none

module ascii_hex_word #(
	parameter int NIBBLES = 4
) (
	// Word to characters
	input  wire logic [4*NIBBLES-1:0] word_in,
	output logic      [8*NIBBLES-1:0] chars_out,
	// Characters to word
	input  wire logic [8*NIBBLES-1:0] chars_in,
	output logic      [4*NIBBLES-1:0] word_out,
	output logic                      chars_ok_out
);

	initial begin
		if (NIBBLES < 1) begin
			$error("ascii_hex_word needs at least one nibble");
		end
	end

	logic [NIBBLES-1:0] nib_ok;

	for (genvar i = 0; i < NIBBLES; i++) begin : g_nib
		logic [3:0] nib;
		logic [7:0] ch;
		assign nib = word_in[4*i +: 4];
		assign ch  = chars_in[8*i +: 8];
		always_comb begin
			chars_out[8*i +: 8] = (nib < 4'hA) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
			nib_ok[i]           = 1'b1;
			word_out[4*i +: 4]  = 4'h0;
			if (ch >= 8'h30 && ch <= 8'h39) begin
				word_out[4*i +: 4] = 4'(ch - 8'h30);
			end else if (ch >= 8'h41 && ch <= 8'h46) begin
				word_out[4*i +: 4] = 4'(ch - 8'h37);
			end else begin
				nib_ok[i] = 1'b0;
			end
		end
	end

	assign chars_ok_out = &nib_ok;

endmodule // ascii_hex_word

`default_nettype wire

// ===== edge_pulse.sv
// Rising-edge detector over a vector of levels, one pulse per 0->1 change.
// Assumes the levels come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module edge_pulse #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             ce_in,
	// Levels and pulses
	input  wire logic [WIDTH-1:0] level_in,
	output logic      [WIDTH-1:0] rise_out
);

	initial begin
		if (WIDTH < 1) begin
			$error("edge_pulse needs WIDTH of at least one");
		end
	end

	logic [WIDTH-1:0] prev;
	logic [WIDTH-1:0] next_prev;

	always_comb begin
		next_prev = ce_in ? level_in : prev;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev <= '0;
		end else begin
			prev <= next_prev;
		end
	end

	// Held levels give no repeat pulse
	assign rise_out = ce_in ? (level_in & ~prev) : '0;

endmodule // edge_pulse

`default_nettype wire

// ===== drive_map_props.sv
// Concurrent checks on the common parameter map's access port.
// Assumes binding to the map's top module, single clock.
`timescale 1ns/100ps
`default_nettype none

module drive_map_props
	import drive_map_pkg::*;
(
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        ce_in,
	// Access and answer
	input wire logic        acc_valid_in,
	input wire logic        acc_write_in,
	input wire logic [15:0] acc_addr_in,
	input wire logic        net_error_in,
	input wire logic        ans_valid_out,
	input wire err_code_t   ans_error_out,
	// Commands
	input wire run_cmd_t    cmd_out,
	input wire logic [15:0] speed_setpoint_out,
	input wire logic        fwd_cmd_out,
	input wire logic        rev_cmd_out,
	input wire logic        net_error_flag_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_taken;
		acc_valid_in && ce_in;
	endsequence

	////////////////////////////////////////////////////////////////////////////
	a_answer_next: assert property (s_taken |=> ans_valid_out)
		else $error("no answer after access");
	a_answer_hold: assert property (!(acc_valid_in && ce_in) |=> $stable(ans_error_out))
		else $error("answer code moved without access");
	a_bad_addr: assert property (s_taken ##0 (acc_addr_in inside {16'h0004,
		[16'h0016:16'h0019]} || acc_addr_in > 16'h001C) |=> ans_error_out == ERR_ILLEGAL_ADDR)
		else $error("unlisted address not refused");
	a_ro_write: assert property (s_taken ##0 acc_write_in && acc_addr_in inside {[16'h0000:16'h0003],
		[16'h0009:16'h0015], [16'h001A:16'h001C]} |=> ans_error_out == ERR_WRITE_MODE)
		else $error("read-only write not refused");
	a_refused_keep: assert property (ans_valid_out && ans_error_out != ERR_NONE
		|-> $stable(speed_setpoint_out))
		else $error("refused write changed setpoint");
	a_reset_once: assert property (cmd_out.fault_reset |=> !cmd_out.fault_reset)
		else $error("fault reset repeated");
	a_stop_clears: assert property (cmd_out.stop || cmd_out.estop |=> !fwd_cmd_out && !rev_cmd_out)
		else $error("stop left a direction latched");
	a_fwd_latch: assert property (cmd_out.forward && !cmd_out.reverse && !cmd_out.stop
		&& !cmd_out.estop |=> fwd_cmd_out && !rev_cmd_out)
		else $error("forward not latched");
	a_net_error: assert property (net_error_in && ce_in |=> net_error_flag_out)
		else $error("network error not flagged");
endmodule // drive_map_props

bind drive_common_param_map drive_map_props i_drive_map_props (.*);

`default_nettype wire

// ===== host_master.sv
// Serial-side master model: one word access at a time, four hex characters.
// Assumes the map answers on the taking edge itself, read back at the following negedge.
`timescale 1ns/100ps
`default_nettype none

module host_master
	import drive_map_pkg::*;
(
	// Clock and answer
	input  wire logic        clk_in,
	input  wire logic        ans_valid_in,
	input  wire err_code_t   ans_error_in,
	input  wire logic [31:0] ans_chars_in,
	input  wire run_cmd_t    cmd_in,
	// Request
	output logic             acc_valid_out,
	output logic             acc_write_out,
	output logic [15:0]      acc_addr_out,
	output logic [31:0]      acc_chars_out
);
	initial begin
		acc_valid_out = 1'b0;
		acc_write_out = 1'b0;
		acc_addr_out = 16'hFFFF;
		acc_chars_out = 32'hFFFFFFFF;
	end

	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] c,
		output logic v, output err_code_t e, output logic [31:0] d, output run_cmd_t k);
		@(negedge clk_in);
		acc_valid_out = 1'b1;
		acc_write_out = w;
		acc_addr_out = a;
		acc_chars_out = c;
		@(negedge clk_in);
		v = ans_valid_in;
		e = ans_error_in;
		d = ans_chars_in;
		k = cmd_in;
		// Released address and character lines show the inverse; the write line keeps its old value
		acc_valid_out = 1'b0;
		acc_addr_out = ~a;
		acc_chars_out = ~c;
	endtask
endmodule // host_master

`default_nettype wire

// ===== drive_common_param_map_tb.sv
// Self-checking bench for the common parameter map.
// Assumes host_master and the checker are compiled beside it.
`timescale 1ns/100ps
`default_nettype none

module drive_common_param_map_tb;
	import drive_map_pkg::*;
	localparam logic [15:0] MC = 16'h005A; // Arbitrary
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic net_err = 1'b0;
	logic ce = 1'b1;
	logic av, aw, v, fwd, rev, nerr, ans_v;
	logic [15:0] aa, spd, ru, rd;
	logic [31:0] ac, ans_c, d;
	err_code_t ans_e, e;
	run_cmd_t cmd, k;
	core_status_t st = 10'h201;
	fault_in_t flt = 14'h0101;
	drive_meas_t meas = {16'h1234, 112'h0, 16'h5678};
	logic [1:0] rsrc = 2'h3;
	logic [6:0] fsrc = 7'h1C;
	logic [15:0] unit = 16'h0001;
	logic [15:0] poles = 16'h0004;
	logic [7:0] opins = 8'h81;
	logic [7:0] ipins = 8'hA5;
	int n_errors = 0;
	int checked = 0;
	logic [15:0] bad [6] = '{16'h0004, 16'h0016, 16'h0017, 16'h0018, 16'h0019, 16'h001D};
	logic [15:0] rw [6] = '{16'h0002, 16'h0002, 16'h0004, 16'h0008, 16'h0008, 16'h0031};
	logic [6:0] rx [6] = '{7'h22, 7'h02, 7'h11, 7'h09, 7'h01, 7'h44};
	logic [15:0] ra [10] = '{16'h0000, 16'h0009, 16'h0015, 16'h000E, 16'h000F,
		16'h0010, 16'h0011, 16'h001A, 16'h001B, 16'h0006};
	logic [15:0] re [10] = '{MC, 16'h1234, 16'h5678, 16'h6401, 16'h8040,
		16'h00A5, 16'h0081, 16'h0001, 16'h0004, 16'h9CD1};

	always #10 clk_in = ~clk_in;

	drive_common_param_map #(.MODEL_CODE(MC)) i_drive_common_param_map (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
		.acc_valid_in(av), .acc_write_in(aw), .acc_addr_in(aa), .acc_chars_in(ac),
		.net_error_in(net_err), .ans_valid_out(ans_v), .ans_error_out(ans_e),
		.ans_chars_out(ans_c), .core_status_in(st), .fault_in(flt), .meas_in(meas),
		.run_source_in(rsrc), .freq_source_in(fsrc), .unit_select_in(unit),
		.pole_count_in(poles), .out_pins_state_in(opins), .in_pins_in(ipins),
		.cmd_out(cmd), .speed_setpoint_out(spd), .ramp_up_time_out(ru),
		.ramp_down_time_out(rd), .fwd_cmd_out(fwd), .rev_cmd_out(rev),
		.net_error_flag_out(nerr));

	host_master i_host_master (
		.clk_in(clk_in), .ans_valid_in(ans_v), .ans_error_in(ans_e), .ans_chars_in(ans_c),
		.cmd_in(cmd), .acc_valid_out(av), .acc_write_out(aw), .acc_addr_out(aa),
		.acc_chars_out(ac));

	////////////////////////////////////////////////////////////////////////////
	// high nibble first, upper-case hex
	function automatic logic [31:0] to_chars(input logic [15:0] w);
		logic [3:0] n;
		for (int i = 0; i < 4; i++) begin
			n = w[15-4*i -: 4];
			to_chars[31-8*i -: 8] = (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
		end
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	task acc(input logic w, input logic [15:0] a, input logic [31:0] c);
		i_host_master.xfer(w, a, c, v, e, d, k);
		chk(32'(v), 32'h1);
	endtask

	task wrap_up;
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge clk_in);
		rst_n_in = 1'b1;
		acc(1'b0, 16'h0007, 32'h0);
		chk(d, to_chars(16'h0032));
		acc(1'b1, 16'h0005, to_chars(16'h0BB8));
		chk(d, 32'h30303030);
		chk(32'(spd), 32'h0BB8);
		acc(1'b1, 16'h0005, to_chars(16'h9C41));
		chk(32'(e), 32'(ERR_ILLEGAL_VALUE));
		chk(d, 32'h30303030);
		acc(1'b1, 16'h0005, 32'h30306162);
		chk(32'(e), 32'(ERR_ILLEGAL_VALUE));
		chk(32'(spd), 32'h0BB8);
		acc(1'b1, 16'h0005, to_chars(16'h9C40));
		chk(d, to_chars(16'h0BB8));
		acc(1'b1, 16'h0007, to_chars(16'h1771));
		chk(32'(e), 32'(ERR_ILLEGAL_VALUE));
		chk(32'(ru), 32'h0032);
		acc(1'b1, 16'h0008, to_chars(16'h1770));
		chk(32'(rd), 32'h1770);
		acc(1'b1, 16'h000E, to_chars(16'h0001));
		chk(32'(e), 32'(ERR_WRITE_MODE));
		foreach (bad[i]) begin
			acc(1'b0, bad[i], 32'h0);
			chk(32'(e), 32'(ERR_ILLEGAL_ADDR));
		end
		foreach (rw[i]) begin
			acc(1'b1, 16'h0006, to_chars(rw[i]));
			chk(32'(k), 32'(rx[i][6:2]));
			@(negedge clk_in);
			chk(32'({fwd, rev}), 32'(rx[i][1:0]));
		end
		net_err = 1'b1;
		@(negedge clk_in);
		net_err = 1'b0;
		chk(32'(nerr), 32'h1);
		// Identity, status, faults, pins and source fields
		foreach (ra[i]) begin
			acc(1'b0, ra[i], 32'h0);
			chk(d, to_chars(re[i]));
		end
		acc(1'b1, 16'h0006, to_chars(16'h0000));
		@(negedge clk_in);
		chk(32'(nerr), 32'h0);
		// Enable low freezes the flag
		ce = 1'b0;
		net_err = 1'b1;
		@(negedge clk_in);
		ce = 1'b1;
		net_err = 1'b0;
		chk(32'(nerr), 32'h0);
		wrap_up;
	end

	// Whole sequence needs under 200 cycles
	initial begin
		#50000;
		n_errors++;
		wrap_up;
	end
endmodule // drive_common_param_map_tb

`default_nettype wire
